/* File: hdl/threshold_alert_ready_logic.sv */
`timescale 1ns/1ns
// Contract
// [R1] Low limit 16-bit signed, resets 8000h
// [R2] High limit 16-bit signed, resets 7FFFh
// [R3] Limits compare against codes, not voltages
// [R4] Host rewrites limits after gain change
// [R5] High sign 1, low sign 0: ready
// [R6] Host keeps high above low normally
// [R7] Single-shot ready: pin shows status bit
// [R8] Continuous ready: pulse per new result
// [R9] Queue sets count; code 11 floats pin
// [R10] Mode bit: traditional or window comparator
// [R11] Latched alert held until read/response
// [R12] Polarity bit sets and inverts active levels
// [R13] Limits and result compared as signed
module threshold_alert_ready_logic (
	// Clock, reset, enable
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic CE_IN,
	// Register port
	input wire logic [1:0] REG_PTR_IN,
	input wire logic REG_WR_IN,
	input wire logic [15:0] REG_WDATA_IN,
	output logic [15:0] REG_RDATA_OUT,
	// Conversion path
	input wire logic [15:0] CONV_DATA_IN,
	input wire logic CONV_VALID_IN,
	input wire logic CONV_READ_IN,
	input wire logic ALERT_RESPONSE_IN,
	// Configuration
	input wire logic CONTINUOUS_MODE_IN,
	input wire logic SINGLE_SHOT_STATUS_IN,
	input wire logic [1:0] ALERT_QUEUE_COUNT_IN,
	input wire logic WINDOW_MODE_IN,
	input wire logic ALERT_LATCH_ENABLE_IN,
	input wire logic ALERT_POLARITY_IN,
	// Alert/ready pin and status
	output logic ALERT_PIN_OUT,
	output logic ALERT_PIN_OE_OUT,
	output logic ALERT_ACTIVE_OUT
);

	logic [15:0] low_limit_reg;
	logic [15:0] low_limit_next;
	logic [15:0] high_limit_reg;
	logic [15:0] high_limit_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic ready_pulse_reg;
	logic ready_pulse_next;
	logic pin_reg;
	logic pin_next;
	logic oe_reg;
	logic oe_next;
	alert_pkg::pin_mode_e pin_mode;
	alert_if bus ();

	// Register write decode
	wire wr_low = REG_WR_IN && (REG_PTR_IN == alert_pkg::PTR_LOW_LIMIT);
	wire wr_high = REG_WR_IN && (REG_PTR_IN == alert_pkg::PTR_HIGH_LIMIT);
	assign low_limit_next = wr_low ? REG_WDATA_IN : low_limit_reg; // [R1]
	assign high_limit_next = wr_high ? REG_WDATA_IN : high_limit_reg; // [R2]

	// Read select; other pointers read zero here, the config path lives elsewhere
	assign rdata_next = (REG_PTR_IN == alert_pkg::PTR_LOW_LIMIT) ? low_limit_reg :
		(REG_PTR_IN == alert_pkg::PTR_HIGH_LIMIT) ? high_limit_reg :
		alert_pkg::READ_ZERO;

	// Ready function from sign bits of the limits [R5]
	wire ready_sel = high_limit_reg[alert_pkg::SIGN_BIT] && !low_limit_reg[alert_pkg::SIGN_BIT];
	wire queue_off = ALERT_QUEUE_COUNT_IN == alert_pkg::QUEUE_OFF;

	// Comparator bundle; limits as signed codes [R13]
	assign bus.result = CONV_DATA_IN;
	assign bus.low_limit = low_limit_reg;
	assign bus.high_limit = high_limit_reg;
	assign bus.result_valid = CONV_VALID_IN;
	assign bus.window_mode = WINDOW_MODE_IN;
	assign bus.latch_en = ALERT_LATCH_ENABLE_IN;
	assign bus.clear_req = CONV_READ_IN || ALERT_RESPONSE_IN; // [R11]
	assign bus.ready_mode = ready_sel;
	assign bus.queue_count = ALERT_QUEUE_COUNT_IN;

	alert_compare u_compare (
		.clk_in(CLK_IN),
		.rst_n_in(RESET_N_IN),
		.ce_in(CE_IN),
		.cmp(bus.comparator)
	);

	// Pin function select; disabled queue floats the pin in every mode
	always_comb begin
		pin_mode = alert_pkg::MODE_OFF;
		if (queue_off) begin
			pin_mode = alert_pkg::MODE_OFF; // [R9]
		end else if (ready_sel) begin
			pin_mode = CONTINUOUS_MODE_IN ? alert_pkg::MODE_READY_CONT :
				alert_pkg::MODE_READY_SINGLE; // [R5]
		end else begin
			pin_mode = alert_pkg::MODE_ALERT;
		end
	end

	// One pulse per new result in continuous ready mode [R8]
	assign ready_pulse_next = CONV_VALID_IN && CONTINUOUS_MODE_IN && ready_sel;

	// Pin level per function; idle level is the inactive one
	always_comb begin
		pin_next = alert_pkg::PIN_RESET;
		oe_next = 1'b1;
		case (pin_mode)
			alert_pkg::MODE_ALERT: begin
				pin_next = bus.alert_active ? ALERT_POLARITY_IN : !ALERT_POLARITY_IN; // [R12]
			end
			alert_pkg::MODE_READY_SINGLE: begin
				pin_next = SINGLE_SHOT_STATUS_IN ^ ALERT_POLARITY_IN; // [R7] [R12]
			end
			alert_pkg::MODE_READY_CONT: begin
				pin_next = ready_pulse_reg ? ALERT_POLARITY_IN : !ALERT_POLARITY_IN; // [R8] [R12]
			end
			alert_pkg::MODE_OFF: begin
				pin_next = alert_pkg::PIN_RESET;
				oe_next = 1'b0; // [R9]
			end
			default: begin
				pin_next = alert_pkg::PIN_RESET;
				oe_next = 1'b0;
			end
		endcase
	end

	// Limit registers; reset wins over the enable
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			low_limit_reg <= alert_pkg::LOW_LIMIT_RESET; // [R1]
			high_limit_reg <= alert_pkg::HIGH_LIMIT_RESET; // [R2]
		end else if (CE_IN) begin
			low_limit_reg <= low_limit_next;
			high_limit_reg <= high_limit_next;
		end
	end

	// Read data and pin drive are registered to keep the pin glitch free
	always_ff @(posedge CLK_IN) begin
		if (!RESET_N_IN) begin
			rdata_reg <= alert_pkg::READ_ZERO;
			ready_pulse_reg <= 1'b0;
			pin_reg <= alert_pkg::PIN_RESET;
			oe_reg <= alert_pkg::OE_RESET;
		end else if (CE_IN) begin
			rdata_reg <= rdata_next;
			ready_pulse_reg <= ready_pulse_next;
			pin_reg <= pin_next;
			oe_reg <= oe_next;
		end
	end

	// Outputs
	assign REG_RDATA_OUT = rdata_reg;
	assign ALERT_PIN_OUT = pin_reg;
	assign ALERT_PIN_OE_OUT = oe_reg;
	assign ALERT_ACTIVE_OUT = bus.alert_active;

	property p_low_reset;
		@(posedge CLK_IN)
		!RESET_N_IN |=> (low_limit_reg == alert_pkg::LOW_LIMIT_RESET);
	endproperty
	a_low_reset: assert property (p_low_reset) else $error("low limit reset value wrong"); // [R1]

	property p_high_reset;
		@(posedge CLK_IN)
		!RESET_N_IN |=> (high_limit_reg == alert_pkg::HIGH_LIMIT_RESET);
	endproperty
	a_high_reset: assert property (p_high_reset) else $error("high limit reset value wrong"); // [R2]

	property p_low_readback;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		(CE_IN && wr_low) ##1 (CE_IN && !REG_WR_IN && REG_PTR_IN == alert_pkg::PTR_LOW_LIMIT)
			|=> (REG_RDATA_OUT == $past(REG_WDATA_IN, 2));
	endproperty
	a_low_readback: assert property (p_low_readback) else $error("low limit readback wrong"); // [R1]

	property p_high_readback;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		(CE_IN && wr_high) ##1 (CE_IN && !REG_WR_IN && REG_PTR_IN == alert_pkg::PTR_HIGH_LIMIT)
			|=> (REG_RDATA_OUT == $past(REG_WDATA_IN, 2));
	endproperty
	a_high_readback: assert property (p_high_readback) else $error("high limit readback wrong"); // [R2]

	property p_ready_select;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		(CE_IN && !queue_off && high_limit_reg[15] && !low_limit_reg[15])
			|=> (ALERT_PIN_OE_OUT && !ALERT_ACTIVE_OUT);
	endproperty
	a_ready_select: assert property (p_ready_select) else $error("ready mode not entered"); // [R5]

	property p_single_follow;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		(CE_IN && pin_mode == alert_pkg::MODE_READY_SINGLE)
			|=> (ALERT_PIN_OUT == ($past(SINGLE_SHOT_STATUS_IN) ^ $past(ALERT_POLARITY_IN)));
	endproperty
	a_single_follow: assert property (p_single_follow) else $error("pin not showing status"); // [R7]

	property p_cont_pulse;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		(CE_IN && CONV_VALID_IN && CONTINUOUS_MODE_IN && ready_sel && !queue_off)
			##1 (CE_IN && pin_mode == alert_pkg::MODE_READY_CONT)
			|=> (ALERT_PIN_OUT == $past(ALERT_POLARITY_IN));
	endproperty
	a_cont_pulse: assert property (p_cont_pulse) else $error("no ready pulse"); // [R8]

	property p_queue_float;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		(CE_IN && queue_off) |=> (!ALERT_PIN_OE_OUT && !ALERT_ACTIVE_OUT);
	endproperty
	a_queue_float: assert property (p_queue_float) else $error("pin driven while disabled"); // [R9]

	property p_latch_hold;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		(CE_IN && ALERT_LATCH_ENABLE_IN && ALERT_ACTIVE_OUT && !CONV_READ_IN &&
			!ALERT_RESPONSE_IN && !queue_off && !ready_sel) |=> ALERT_ACTIVE_OUT;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latched alert dropped"); // [R11]

	property p_alert_level;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		(CE_IN && pin_mode == alert_pkg::MODE_ALERT)
			|=> (ALERT_PIN_OUT == ($past(bus.alert_active) ~^ $past(ALERT_POLARITY_IN)));
	endproperty
	a_alert_level: assert property (p_alert_level) else $error("alert level wrong"); // [R12]

	property p_window_low;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		(CE_IN && WINDOW_MODE_IN && !queue_off && !ready_sel && CONV_VALID_IN &&
			ALERT_QUEUE_COUNT_IN == alert_pkg::QUEUE_ONE &&
			$signed(CONV_DATA_IN) < $signed(low_limit_reg)) |=> ALERT_ACTIVE_OUT;
	endproperty
	a_window_low: assert property (p_window_low) else $error("window low side missed"); // [R10]

	property p_trad_low;
		@(posedge CLK_IN) disable iff (!RESET_N_IN)
		(CE_IN && !WINDOW_MODE_IN && !ALERT_LATCH_ENABLE_IN && !queue_off && !ready_sel &&
			CONV_VALID_IN && $signed(CONV_DATA_IN) < $signed(low_limit_reg) &&
			$signed(CONV_DATA_IN) <= $signed(high_limit_reg)) |=> !ALERT_ACTIVE_OUT;
	endproperty
	a_trad_low: assert property (p_trad_low) else $error("traditional alert not cleared"); // [R13]

endmodule

/* File: hdl/alert_pkg.sv */
package alert_pkg;

	// Register pointer codes on the register port
	localparam logic [1:0] PTR_LOW_LIMIT = 2'h2;
	localparam logic [1:0] PTR_HIGH_LIMIT = 2'h3;

	// Limit register values after reset: most negative and most positive codes
	localparam logic [15:0] LOW_LIMIT_RESET = 16'h8000;
	localparam logic [15:0] HIGH_LIMIT_RESET = 16'h7FFF;
	localparam logic [15:0] READ_ZERO = 16'h0000;

	// Sign bit position of a limit
	localparam int SIGN_BIT = 15;

	// Queue field codes
	typedef enum logic [1:0] {
		QUEUE_ONE = 2'b00,
		QUEUE_TWO = 2'b01,
		QUEUE_FOUR = 2'b10,
		QUEUE_OFF = 2'b11
	} queue_e;

	// Consecutive out-of-limit conversions needed per queue code
	localparam logic [2:0] COUNT_ZERO = 3'h0;
	localparam logic [2:0] COUNT_STEP = 3'h1;
	localparam logic [2:0] COUNT_ONE = 3'h1;
	localparam logic [2:0] COUNT_TWO = 3'h2;
	localparam logic [2:0] COUNT_FOUR = 3'h4;

	// Pin function selected from limits and configuration
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_ALERT = 2'b01,
		MODE_READY_SINGLE = 2'b10,
		MODE_READY_CONT = 2'b11
	} pin_mode_e;

	// Pin state after reset: released, idle high
	localparam logic PIN_RESET = 1'b1;
	localparam logic OE_RESET = 1'b0;

endpackage

/* File: hdl/alert_if.sv */
`timescale 1ns/1ns
interface alert_if;
	logic signed [15:0] result;
	logic signed [15:0] low_limit;
	logic signed [15:0] high_limit;
	logic result_valid;
	logic window_mode;
	logic latch_en;
	logic clear_req;
	logic ready_mode;
	logic [1:0] queue_count;
	logic alert_active;

	// Top side drives configuration and samples
	modport host (
		output result, low_limit, high_limit, result_valid, window_mode,
		output latch_en, clear_req, ready_mode, queue_count,
		input alert_active
	);

	// Comparator side
	modport comparator (
		input result, low_limit, high_limit, result_valid, window_mode,
		input latch_en, clear_req, ready_mode, queue_count,
		output alert_active
	);
endinterface

/* File: hdl/alert_compare.sv */
`timescale 1ns/1ns
module alert_compare (
	// Clock and control
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// Comparator bundle
	alert_if.comparator cmp
);

	logic [2:0] count_reg;
	logic [2:0] count_next;
	logic alert_reg;
	logic alert_next;

	// Signed comparison of codes, not voltages [R3] [R13]
	wire above = cmp.result > cmp.high_limit;
	wire below = cmp.result < cmp.low_limit;
	// Window counts both sides; traditional only the upper [R10]
	wire outside = cmp.window_mode ? (above || below) : above;
	// Traditional clears only below the low limit, giving hysteresis [R10]
	wire back_inside = cmp.window_mode ? !(above || below) : below;
	wire disabled = (cmp.queue_count == alert_pkg::QUEUE_OFF) || cmp.ready_mode;

	// Needed count per queue code [R9]
	wire [2:0] need = (cmp.queue_count == alert_pkg::QUEUE_ONE) ? alert_pkg::COUNT_ONE :
		(cmp.queue_count == alert_pkg::QUEUE_TWO) ? alert_pkg::COUNT_TWO :
		alert_pkg::COUNT_FOUR;
	// Saturate so a long excursion never wraps back below the need
	wire [2:0] count_inc = (count_reg == alert_pkg::COUNT_FOUR) ? count_reg :
		3'(count_reg + alert_pkg::COUNT_STEP);
	wire set_evt = cmp.result_valid && outside && (count_inc >= need); // [R9]
	// Latched alert waits for a data read or alert response [R11]
	wire clr_evt = cmp.latch_en ? cmp.clear_req : (cmp.result_valid && back_inside);

	// Next state; set wins over a same-cycle clear
	assign count_next = disabled ? alert_pkg::COUNT_ZERO :
		!cmp.result_valid ? count_reg :
		outside ? count_inc : alert_pkg::COUNT_ZERO;
	assign alert_next = disabled ? 1'b0 : set_evt ? 1'b1 : clr_evt ? 1'b0 : alert_reg; // [R11]
	assign cmp.alert_active = alert_reg;

	// Queue counter and alert flag
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			count_reg <= alert_pkg::COUNT_ZERO;
			alert_reg <= 1'b0;
		end else if (ce_in) begin
			count_reg <= count_next;
			alert_reg <= alert_next;
		end
	end

	property p_queue_one;
		@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && !disabled && cmp.queue_count == alert_pkg::QUEUE_ONE &&
			cmp.result_valid && outside) |=> alert_reg;
	endproperty
	a_queue_one: assert property (p_queue_one) else $error("single excursion did not alert"); // [R9]

	property p_queue_two_wait;
		@(posedge clk_in) disable iff (!rst_n_in)
		(ce_in && !disabled && !alert_reg && cmp.queue_count == alert_pkg::QUEUE_TWO &&
			cmp.result_valid && outside && count_reg == alert_pkg::COUNT_ZERO) |=> !alert_reg;
	endproperty
	a_queue_two_wait: assert property (p_queue_two_wait) else $error("alert after one of two"); // [R9]

endmodule

/* File: dv/limit_host_model.sv */
`timescale 1ns/1ns
module limit_host_model (
	// Clock
	input wire logic clk_in,
	// Register port
	output logic [1:0] reg_ptr_out,
	output logic reg_wr_out,
	output logic [15:0] reg_wdata_out,
	input wire logic [15:0] reg_rdata_in
);
	// Idle on a pointer that reads zero
	initial begin
		reg_ptr_out = 2'h0;
		reg_wr_out = 1'b0;
		reg_wdata_out = 16'h0000;
	end

	// One-cycle strobe with a whole word, driven off the sampling edge
	task automatic write_reg(input logic [1:0] ptr, input logic [15:0] data);
		@(negedge clk_in);
		reg_ptr_out = ptr;
		reg_wdata_out = data;
		reg_wr_out = 1'b1;
		@(negedge clk_in);
		reg_wr_out = 1'b0;
		reg_wdata_out = ~data; // No stale word left for a missed strobe to pick up
	endtask

	// Read data is registered, so wait two edges after presenting the pointer
	task automatic read_reg(input logic [1:0] ptr, output logic [15:0] data);
		@(negedge clk_in);
		reg_ptr_out = ptr;
		@(negedge clk_in);
		@(negedge clk_in);
		data = reg_rdata_in;
	endtask

	// Limits always rewritten as a pair, high above low unless ready is wanted
	task automatic set_limits(input logic [15:0] low, input logic [15:0] high);
		write_reg(alert_pkg::PTR_LOW_LIMIT, low);
		write_reg(alert_pkg::PTR_HIGH_LIMIT, high);
	endtask
endmodule

/* File: dv/threshold_alert_ready_logic_tb.sv */
`timescale 1ns/1ns
module threshold_alert_ready_logic_tb;
	logic clk, rst_n, ce, wr, valid, rd_pulse, resp, cont, ss, win, latch, pol;
	logic [1:0] ptr, queue;
	logic [15:0] wdata, rdata, data, got;
	logic pin, oe, active;
	int miscompares = 0;
	int total_checks = 0;
	int hits;
	int n;

	limit_host_model u_limit_host_model (.clk_in(clk), .reg_ptr_out(ptr), .reg_wr_out(wr),
		.reg_wdata_out(wdata), .reg_rdata_in(rdata));

	threshold_alert_ready_logic u_threshold_alert_ready_logic (.CLK_IN(clk), .RESET_N_IN(rst_n),
		.CE_IN(ce), .REG_PTR_IN(ptr), .REG_WR_IN(wr), .REG_WDATA_IN(wdata),
		.REG_RDATA_OUT(rdata), .CONV_DATA_IN(data), .CONV_VALID_IN(valid),
		.CONV_READ_IN(rd_pulse), .ALERT_RESPONSE_IN(resp), .CONTINUOUS_MODE_IN(cont),
		.SINGLE_SHOT_STATUS_IN(ss), .ALERT_QUEUE_COUNT_IN(queue), .WINDOW_MODE_IN(win),
		.ALERT_LATCH_ENABLE_IN(latch), .ALERT_POLARITY_IN(pol), .ALERT_PIN_OUT(pin),
		.ALERT_PIN_OE_OUT(oe), .ALERT_ACTIVE_OUT(active));

	// Free-running clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
		total_checks++;
		if (exp !== seen) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rd(input logic [1:0] p, input logic [15:0] exp);
		u_limit_host_model.read_reg(p, got);
		chk("read data", exp, got);
	endtask

	// One result; counts cycles the pin sits at the asserted level
	task automatic conv(input logic [15:0] d);
		@(negedge clk);
		data = d;
		valid = 1'b1;
		hits = 0;
		repeat (4) begin
			@(negedge clk);
			valid = 1'b0;
			data = ~d; // Result bus not held once the strobe is gone
			if (pin === pol)
				hits++;
		end
	endtask

	// Clear strobes: bit 0 conversion read, bit 1 alert response
	task automatic clr(input logic [1:0] which);
		@(negedge clk);
		rd_pulse = which[0];
		resp = which[1];
		@(negedge clk);
		rd_pulse = 1'b0;
		resp = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	task automatic finish_test();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Hang guard at 20000 cycles, well beyond the couple of hundred cycles the sequence needs
	initial begin
		#(50 * 20000);
		miscompares++;
		finish_test();
	end

	// Main sequence
	initial begin
		{rst_n, ce, valid, rd_pulse, resp, ss, win, latch, pol} = 9'h080;
		cont = 1'b1;
		queue = 2'b11;
		data = 16'h0000;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		rd(2'h2, 16'h8000);
		rd(2'h3, 16'h7FFF);
		chk("pin enable", 16'h0000, 16'(oe));
		u_limit_host_model.write_reg(2'h1, 16'h1234);
		rd(2'h1, 16'h0000);
		ce = 1'b0;
		u_limit_host_model.write_reg(2'h2, 16'h5555);
		ce = 1'b1;
		rd(2'h2, 16'h8000);
		u_limit_host_model.set_limits(16'hFF9C, 16'h0064);
		rd(2'h2, 16'hFF9C);
		rd(2'h3, 16'h0064);
		// Each queue code needs its own run of out-of-limit results
		for (int q = 0; q < 3; q++) begin
			queue = q[1:0];
			n = 1 << q;
			for (int i = 0; i < n; i++) begin
				conv(16'h0065);
				chk("alert active", 16'(i == n - 1), 16'(active));
			end
			chk("alert pin", 16'h0000, 16'(pin));
			chk("pin enable", 16'h0001, 16'(oe));
			conv(16'hFF00);
			chk("alert active", 16'h0000, 16'(active));
		end
		queue = 2'b00; // Single excursion again, so each side alerts at once
		win = 1'b1;
		conv(16'hFF9B);
		chk("alert active", 16'h0001, 16'(active));
		conv(16'h0000);
		chk("alert active", 16'h0000, 16'(active));
		win = 1'b0;
		latch = 1'b1;
		for (int c = 1; c < 3; c++) begin
			conv(16'h0065);
			conv(16'hFF00);
			chk("alert active", 16'h0001, 16'(active));
			clr(c[1:0]);
			chk("alert active", 16'h0000, 16'(active));
		end
		conv(16'h0065);
		pol = 1'b1;
		repeat (3) @(negedge clk);
		chk("alert pin", 16'h0001, 16'(pin));
		clr(2'h1);
		queue = 2'b11;
		repeat (3) @(negedge clk);
		chk("pin enable", 16'h0000, 16'(oe));
		chk("alert active", 16'h0000, 16'(active));
		queue = 2'b00;
		latch = 1'b0;
		u_limit_host_model.set_limits(16'h0000, 16'h8000);
		// Continuous ready: one asserted cycle per result, both polarities
		for (int p = 0; p < 2; p++) begin
			pol = p[0];
			repeat (3) @(negedge clk);
			conv(16'h7000);
			chk("ready pulse cycles", 16'h0001, 16'(hits));
			chk("alert active", 16'h0000, 16'(active));
		end
		cont = 1'b0;
		// Single-shot ready: pin follows the status bit
		for (int k = 0; k < 4; k++) begin
			{ss, pol} = k[1:0];
			repeat (3) @(negedge clk);
			chk("ready level", 16'(k[1] ^ k[0]), 16'(pin));
		end
		finish_test();
	end
endmodule
